// ==== pesc_counter.sv ====
// One counter that adds one per qualifying cycle.
`timescale 1ns/1ps
module pesc_counter
    import pesc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic inc,
    output logic [PESC_CNT_W-1:0] count_q
);

    logic [PESC_CNT_W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (clear) begin
            count_d = PESC_CNT_RST;
        end else if (inc) begin
            count_d = count_q + {{(PESC_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= PESC_CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : pesc_counter

// ==== pesc_pkg.sv ====
// Package for the performance event selection and counting block.
package pesc_pkg;

    localparam int PESC_CNT_W = 48;
    localparam int PESC_NUM_PROG = 2;
    localparam int PESC_NUM_FIXED = 3;

    localparam logic [7:0] PESC_EV_QUEUE_REJECT = 8'h31;
    localparam logic [7:0] PESC_EV_CLK_UNHALTED = 8'h3C;
    localparam logic [7:0] PESC_EV_ICACHE = 8'h80;
    localparam logic [7:0] PESC_EV_OFFCORE = 8'hB7;
    localparam logic [7:0] PESC_EV_INST_RETIRED = 8'hC0;

    localparam logic [7:0] PESC_UM_00 = 8'h00;
    localparam logic [7:0] PESC_UM_01 = 8'h01;
    localparam logic [7:0] PESC_UM_02 = 8'h02;
    localparam logic [7:0] PESC_UM_03 = 8'h03;

    localparam int PESC_FIX_INST = 0;
    localparam int PESC_FIX_CORE = 1;
    localparam int PESC_FIX_REF = 2;

    localparam logic [PESC_CNT_W-1:0] PESC_CNT_RST = 48'h0;

    // Reference clock enable divider: reference pulses come at max-frequency rate
    localparam logic [7:0] PESC_REF_DIV_RST = 8'h00;

    typedef struct packed {
        logic       enable;
        logic [7:0] event_num;
        logic [7:0] unit_mask;
    } pesc_sel_t;

    typedef struct packed {
        logic halted;
        logic ref_tick;
        logic fetch_valid;
        logic fetch_hit;
        logic fetch_uncacheable;
        logic miss_start;
        logic retire_last_uop;
        logic rej_full;
        logic rej_ext_full;
        logic rej_fairness;
        logic rej_evict_conflict;
        logic l2_pf_drop;
        logic offcore_match_a;
        logic offcore_match_b;
    } pesc_events_t;

    typedef struct packed {
        logic inst;
        logic core;
        logic refc;
    } pesc_fixed_en_t;

endpackage : pesc_pkg

// ==== pesc_top.sv ====
// Event selection and counting for the core performance monitor.
// Operation
// (R1) Event 3CH mask 00H counts every core cycle not halted.
// (R2) Fixed counter 1 counts the same unhalted core cycles.
// (R3) Event 3CH mask 01H counts reference cycles at maximum-frequency rate.
// (R4) Fixed counter 2 counts the same unhalted reference cycles.
// (R5) Event 80H mask 01H counts fetches served by the instruction cache.
// (R6) Event 80H mask 02H counts fetch misses and uncacheable fetches.
// (R7) A fetch miss counts once, not each outstanding cycle.
// (R8) Event 80H mask 03H counts every fetch, cacheable or not.
// (R9) Event C0H mask 00H counts an instruction at its last micro-op.
// (R10) Retired counting continues during interrupts, traps and handlers.
// (R11) Fixed counter 0 counts the same retired instructions.
// (R12) Event 31H counts demand and first-level prefetch rejects when queue full.
// (R13) Queue rejects include external-queue-bound requests refused for fullness.
// (R14) Fairness rejects with free space are counted too.
// (R15) Dirty evictions conflicting with pending requests may be rejected and counted.
// (R16) Dropped second-level prefetches are not counted as rejects.
// (R17) Software programs response selection registers before off-core events.
// (R18) Second-level misses move from request queue to external queue.
// (R19) A counter adds one only when event number and mask both match.
`timescale 1ns/1ps
module pesc_top
    import pesc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pesc_sel_t sel_0,
    input wire pesc_sel_t sel_1,
    input wire pesc_fixed_en_t fixed_en,
    input wire logic [PESC_NUM_PROG-1:0] prog_clear,
    input wire logic [PESC_NUM_FIXED-1:0] fixed_clear,
    input wire pesc_events_t events,
    input wire logic l2_miss,
    output logic forward_to_ext_queue_q,
    output logic [PESC_CNT_W-1:0] prog_count_0,
    output logic [PESC_CNT_W-1:0] prog_count_1,
    output logic [PESC_CNT_W-1:0] fixed_count_inst,
    output logic [PESC_CNT_W-1:0] fixed_count_core,
    output logic [PESC_CNT_W-1:0] fixed_count_ref
);

    logic unhalted_core;
    logic unhalted_ref;
    logic fetch_hit_ev;
    logic fetch_miss_ev;
    logic fetch_any_ev;
    logic inst_retired_ev;
    logic queue_reject_ev;
    logic miss_seen_q;
    logic miss_once;
    logic [PESC_NUM_PROG-1:0] prog_inc;
    logic [PESC_NUM_FIXED-1:0] fixed_inc;
    pesc_sel_t sel [PESC_NUM_PROG];
    logic [PESC_CNT_W-1:0] prog_cnt [PESC_NUM_PROG];
    logic [PESC_CNT_W-1:0] fixed_cnt [PESC_NUM_FIXED];

    assign sel[0] = sel_0;
    assign sel[1] = sel_1;

    // Halt comes only from the halt_instruction state
    assign unhalted_core = !events.halted; // R1
    // Reference tick is a fixed-rate enable, independent of core frequency
    assign unhalted_ref = !events.halted && events.ref_tick; // R3

    // Miss input is a level while outstanding; count its leading edge only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            miss_seen_q <= 1'b0;
        end else begin
            miss_seen_q <= events.miss_start; // R7
        end
    end
    assign miss_once = events.miss_start && !miss_seen_q; // R7

    assign fetch_hit_ev = events.fetch_valid && events.fetch_hit
        && !events.fetch_uncacheable; // R5
    assign fetch_miss_ev = miss_once
        || (events.fetch_valid && events.fetch_uncacheable); // R6
    assign fetch_any_ev = events.fetch_valid; // R8

    // Interrupt state is deliberately not an input: nothing suspends this
    assign inst_retired_ev = events.retire_last_uop; // R9 R10

    assign queue_reject_ev = (events.rej_full // R12
        || events.rej_ext_full // R13
        || events.rej_fairness // R14
        || events.rej_evict_conflict) // R15
        && !events.l2_pf_drop; // R16

    // Second-level misses are handed on one cycle later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            forward_to_ext_queue_q <= 1'b0;
        end else begin
            forward_to_ext_queue_q <= l2_miss; // R18
        end
    end

    function automatic logic pesc_match(input pesc_sel_t s,
                                        input logic core_c,
                                        input logic ref_c,
                                        input logic f_hit,
                                        input logic f_miss,
                                        input logic f_any,
                                        input logic ret,
                                        input logic rej,
                                        input logic off_a,
                                        input logic off_b);
        logic m;
        m = 1'b0;
        if (s.enable) begin
            unique case (s.event_num)
                PESC_EV_CLK_UNHALTED: begin
                    if (s.unit_mask == PESC_UM_00) m = core_c; // R1
                    else if (s.unit_mask == PESC_UM_01) m = ref_c; // R3
                end
                PESC_EV_ICACHE: begin
                    if (s.unit_mask == PESC_UM_01) m = f_hit; // R5
                    else if (s.unit_mask == PESC_UM_02) m = f_miss; // R6
                    else if (s.unit_mask == PESC_UM_03) m = f_any; // R8
                end
                PESC_EV_INST_RETIRED: begin
                    if (s.unit_mask == PESC_UM_00) m = ret; // R9
                end
                PESC_EV_QUEUE_REJECT: begin
                    if (s.unit_mask == PESC_UM_00) m = rej; // R12
                end
                PESC_EV_OFFCORE: begin
                    // Match inputs come from the response selection registers
                    if (s.unit_mask == PESC_UM_01) m = off_a; // R17
                    else if (s.unit_mask == PESC_UM_02) m = off_b; // R17
                end
                default: m = 1'b0; // R19
            endcase
        end
        return m;
    endfunction : pesc_match

    genvar gi;
    generate
        for (gi = 0; gi < PESC_NUM_PROG; gi++) begin : g_prog
            assign prog_inc[gi] = pesc_match(sel[gi], unhalted_core, unhalted_ref,
                fetch_hit_ev, fetch_miss_ev, fetch_any_ev, inst_retired_ev,
                queue_reject_ev, events.offcore_match_a,
                events.offcore_match_b); // R19
            pesc_counter u_prog (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .clear(prog_clear[gi]),
                .inc(prog_inc[gi]),
                .count_q(prog_cnt[gi])
            );
        end
    endgenerate

    assign fixed_inc[PESC_FIX_INST] = fixed_en.inst && inst_retired_ev; // R11
    assign fixed_inc[PESC_FIX_CORE] = fixed_en.core && unhalted_core; // R2
    assign fixed_inc[PESC_FIX_REF] = fixed_en.refc && unhalted_ref; // R4

    generate
        for (gi = 0; gi < PESC_NUM_FIXED; gi++) begin : g_fixed
            pesc_counter u_fixed (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .clear(fixed_clear[gi]),
                .inc(fixed_inc[gi]),
                .count_q(fixed_cnt[gi])
            );
        end
    endgenerate

    assign prog_count_0 = prog_cnt[0];
    assign prog_count_1 = prog_cnt[1];
    assign fixed_count_inst = fixed_cnt[PESC_FIX_INST];
    assign fixed_count_core = fixed_cnt[PESC_FIX_CORE];
    assign fixed_count_ref = fixed_cnt[PESC_FIX_REF];

endmodule : pesc_top

// ==== pesc_top_properties.sv ====
// Checker for the event selection and counting block, bound to its top module.
`timescale 1ns/1ps
module pesc_top_properties
    import pesc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pesc_sel_t sel_0,
    input wire pesc_sel_t sel_1,
    input wire pesc_fixed_en_t fixed_en,
    input wire logic [PESC_NUM_PROG-1:0] prog_clear,
    input wire logic [PESC_NUM_FIXED-1:0] fixed_clear,
    input wire pesc_events_t events,
    input wire logic l2_miss,
    input wire logic forward_to_ext_queue_q,
    input wire logic [PESC_CNT_W-1:0] prog_count_0,
    input wire logic [PESC_CNT_W-1:0] prog_count_1,
    input wire logic [PESC_CNT_W-1:0] fixed_count_inst,
    input wire logic [PESC_CNT_W-1:0] fixed_count_core,
    input wire logic [PESC_CNT_W-1:0] fixed_count_ref
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    core_cycle_a: assert property (sel_0 == {1'b1, 8'h3C, 8'h00} && !prog_clear[0]
        |=> prog_count_0 == $past(prog_count_0) + 48'(!$past(events.halted)))
        else $error("core cycle count wrong");
    ref_cycle_a: assert property (sel_1 == {1'b1, 8'h3C, 8'h01} && !prog_clear[1]
        |=> prog_count_1 == $past(prog_count_1)
            + 48'($past(events.ref_tick) && !$past(events.halted)))
        else $error("reference cycle count wrong");
    miss_once_a: assert property (sel_0 == {1'b1, 8'h80, 8'h02} && !prog_clear[0]
        && events.miss_start && $past(events.miss_start) && !events.fetch_valid
        |=> $stable(prog_count_0)) else $error("outstanding miss counted again");
    retire_count_a: assert property (sel_0 == {1'b1, 8'hC0, 8'h00} && !prog_clear[0]
        |=> prog_count_0 == $past(prog_count_0) + 48'($past(events.retire_last_uop)))
        else $error("retired count wrong");
    reject_count_a: assert property (sel_1 == {1'b1, 8'h31, 8'h00} && !prog_clear[1]
        |=> prog_count_1 == $past(prog_count_1) + 48'(!$past(events.l2_pf_drop)
            && ($past(events.rej_full) || $past(events.rej_ext_full)
            || $past(events.rej_fairness) || $past(events.rej_evict_conflict))))
        else $error("reject count wrong");
    fixed_core_a: assert property (fixed_en.core && !fixed_clear[1]
        |=> fixed_count_core == $past(fixed_count_core) + 48'(!$past(events.halted)))
        else $error("fixed core count wrong");
    fixed_ref_a: assert property (fixed_en.refc && !fixed_clear[2]
        |=> fixed_count_ref == $past(fixed_count_ref)
            + 48'($past(events.ref_tick) && !$past(events.halted)))
        else $error("fixed reference count wrong");
    fixed_inst_a: assert property (fixed_en.inst && !fixed_clear[0]
        |=> fixed_count_inst == $past(fixed_count_inst) + 48'($past(events.retire_last_uop)))
        else $error("fixed retired count wrong");
    forward_delay_a: assert property (l2_miss != forward_to_ext_queue_q
        |=> forward_to_ext_queue_q == $past(l2_miss)) else $error("forward flag late");
    idle_hold_a: assert property (!sel_1.enable && !prog_clear[1]
        |=> $stable(prog_count_1)) else $error("disabled counter moved");

    cover property (sel_1 == {1'b1, 8'h31, 8'h00} && events.rej_fairness);
    cover property (sel_0 == {1'b1, 8'h80, 8'h02} && events.miss_start);
    cover property (fixed_en.refc && events.ref_tick && !events.halted);
endmodule : pesc_top_properties

bind pesc_top pesc_top_properties chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .sel_0(sel_0),
    .sel_1(sel_1), .fixed_en(fixed_en), .prog_clear(prog_clear), .fixed_clear(fixed_clear),
    .events(events), .l2_miss(l2_miss), .forward_to_ext_queue_q(forward_to_ext_queue_q),
    .prog_count_0(prog_count_0), .prog_count_1(prog_count_1),
    .fixed_count_inst(fixed_count_inst), .fixed_count_core(fixed_count_core),
    .fixed_count_ref(fixed_count_ref));

// ==== tb_pesc_top.sv ====
// Self-checking testbench for the event selection and counting block.
`timescale 1ns/1ps
module tb_pesc_top
    import pesc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    pesc_sel_t sel_0 = '0;
    pesc_sel_t sel_1 = '0;
    pesc_fixed_en_t fixed_en = '0;
    logic [1:0] prog_clear = '0;
    logic [2:0] fixed_clear = '0;
    pesc_events_t events = '0;
    logic l2_miss = 1'b0;
    logic fwd;
    logic [47:0] c0, c1, ci, cc, cr;
    int n_fail = 0;
    int tests_run = 0;

    pesc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .sel_0(sel_0), .sel_1(sel_1),
        .fixed_en(fixed_en), .prog_clear(prog_clear), .fixed_clear(fixed_clear),
        .events(events), .l2_miss(l2_miss), .forward_to_ext_queue_q(fwd),
        .prog_count_0(c0), .prog_count_1(c1), .fixed_count_inst(ci),
        .fixed_count_core(cc), .fixed_count_ref(cr));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task report_and_stop;
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t count %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // Clear edge: the selectors take effect together with the clear
    task arm(input logic [7:0] e0, m0, e1, m1, input logic en1);
        @(posedge sys_clk);
        #1 sel_0 = {1'b1, e0, m0};
        sel_1 = {en1, e1, m1};
        prog_clear = '1;
        fixed_clear = '1;
    endtask : arm

    // Bits: halted ref fetch hit unc miss retire full ext fair evict drop a b
    task cyc(input logic [13:0] e);
        @(posedge sys_clk);
        #1 events = e;
        prog_clear = '0;
        fixed_clear = '0;
    endtask : cyc

    task t_cycles;
        arm(8'h3C, 8'h00, 8'h3C, 8'h01, 1'b1);
        for (int i = 0; i < 10; i++) cyc({(i >= 6), ~i[0], 12'h000});
        cyc(14'h0000);
        chk(c0, 48'h6);
        chk(c1, 48'h3);
        chk(cc, 48'h6);
        chk(cr, 48'h3);
    endtask : t_cycles

    task t_fetch;
        for (int k = 1; k <= 3; k++) begin
            arm(8'h80, 8'(k), 8'h80, 8'h03, 1'b0);
            cyc(14'h0C00);
            cyc(14'h0A00);
            repeat (4) cyc(14'h0100);
            cyc(14'h0000);
            cyc(14'h0100);
            cyc(14'h0000);
            chk(c0, 48'(k == 2 ? 3 : (k == 1 ? 1 : 2)));
            chk(c1, 48'h0);
        end
    endtask : t_fetch

    task t_retire;
        arm(8'hC0, 8'h00, 8'h31, 8'h00, 1'b1);
        cyc(14'h00C0);
        cyc(14'h0020);
        cyc(14'h0090);
        cyc(14'h0008);
        cyc(14'h0044);
        cyc(14'h20E0);
        cyc(14'h0000);
        chk(c0, 48'h3);
        chk(ci, 48'h3);
        chk(c1, 48'h5);
    endtask : t_retire

    task t_offcore;
        arm(8'hB7, 8'h01, 8'hB7, 8'h02, 1'b1);
        cyc(14'h0002);
        cyc(14'h0003);
        cyc(14'h0800);
        cyc(14'h0000);
        chk(c0, 48'h2);
        chk(c1, 48'h1);
    endtask : t_offcore

    task t_forward;
        @(posedge sys_clk);
        #1 l2_miss = 1'b1;
        @(posedge sys_clk);
        #1 chk(48'(fwd), 48'h1);
        l2_miss = 1'b0;
        @(posedge sys_clk);
        #1 chk(48'(fwd), 48'h0);
    endtask : t_forward

    initial begin
        fixed_en = '1;
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_cycles();
        t_fetch();
        t_retire();
        t_offcore();
        t_forward();
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        report_and_stop();
    end
endmodule : tb_pesc_top
